// *** hw/io_status_probe_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Input word bit 0 negative overtravel, bit 1 positive, bit 2 home; 1 is on.
// - Input word bits 16-20 mirror connector inputs, 0 active; bits 3-15 reserved.
// - Inputs allocated as remote reach only the host, never drive functions.
// - Output object holds request word and mask; bit acts only when masked in.
// - Request bits 16-20 drive only general-purpose connector outputs.
// - Each allocated general-purpose output has its own polarity inversion.
// - General-purpose bus output bits act only when also bus-enabled; else internal control.
// - Request bits from 24 drive remote connector outputs per remote allocation.
// - Output bits 16-20 and 24-25: 0 active, 1 inactive; others reserved.
// - Probe captures feedback position on trigger from probe pins or zero pulse.
// - Two concurrent channels: bits 0-7 and 8-15 of control and status.
// - Each channel stores rising and falling captures in separate registers.
// - Control bits 0 and 8 enable channel one and channel two.
// - Control bits 1 and 9: 0 first event only, 1 every event.
// - Control bit 2 picks probe input one or zero pulse for channel one.
// - Control bit 10 picks probe input two or zero pulse for channel two.
// - Control bits 4 and 5 enable rising and falling capture, channel one.
// - Control bits 12 and 13 enable rising and falling capture, channel two.
// - Status shows enabled, rise stored, fall stored, and wrapping two-bit count.
// - Probe pins filtered; filter time in 10 ns units, 0-200, taken at restart.
module io_status_probe_top (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire io_probe_pkg::od_req_type od_req_i,
    output logic [31:0] od_rdata_o,
    output logic od_ack_o,
    output logic od_abort_o,
    input wire logic neg_overtravel_i,
    input wire logic positive_overtravel_i,
    input wire logic home_switch_i,
    input wire logic [io_probe_pkg::NUM_CONN-1:0] connector_in_i,
    input wire logic probe_input_one_i,
    input wire logic probe_input_two_i,
    input wire logic encoder_zero_i,
    input wire logic [31:0] feedback_position_i,
    input wire logic [io_probe_pkg::NUM_CONN-1:0] remote_input_sel_i,
    input wire logic [io_probe_pkg::NUM_CONN-1:0] bus_output_enable_i,
    input wire logic [io_probe_pkg::NUM_CONN-1:0] output_polarity_i,
    input wire logic [io_probe_pkg::NUM_REMOTE-1:0] remote_output_allocation_i,
    input wire logic [io_probe_pkg::NUM_CONN-1:0] internal_out_active_i,
    input wire logic [7:0] probe_filter_time_i,
    output logic [io_probe_pkg::NUM_CONN-1:0] drive_input_active_o,
    output logic [io_probe_pkg::NUM_CONN-1:0] general_out_o,
    output logic [io_probe_pkg::NUM_REMOTE-1:0] remote_out_o
);
    import io_probe_pkg::*;

    localparam int NUM_PINS = NUM_CONN + 6;

    // Reset release
    logic rst_a_q, rst_b_q;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_b_q <= rst_a_q;
        end
    end

    assign rst_n = rst_b_q;

    // Pin synchronisers
    logic [NUM_PINS-1:0] pins;
    logic [NUM_PINS-1:0] sync_a_q, sync_a_d;
    logic [NUM_PINS-1:0] sync_b_q, sync_b_d;
    logic neg_ot, pos_ot, home;
    logic [NUM_CONN-1:0] conn;
    logic ext_one, ext_two, zero_pulse;

    always_comb begin
        pins = {encoder_zero_i, probe_input_two_i, probe_input_one_i,
                connector_in_i, home_switch_i, positive_overtravel_i,
                neg_overtravel_i};
        sync_a_d = pins;
        sync_b_d = sync_a_q;
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync_a_q <= '0;
            sync_b_q <= '0;
        end else begin
            sync_a_q <= sync_a_d;
            sync_b_q <= sync_b_d;
        end
    end

    always_comb begin
        neg_ot = sync_b_q[0];
        pos_ot = sync_b_q[1];
        home = sync_b_q[2];
        conn = sync_b_q[3 +: NUM_CONN];
        ext_one = sync_b_q[NUM_CONN + 3];
        ext_two = sync_b_q[NUM_CONN + 4];
        zero_pulse = sync_b_q[NUM_CONN + 5];
    end

    // Filter time is sampled once after reset; later changes wait for restart
    logic taken_q, taken_d;
    logic [FILTER_CNT_W-1:0] limit_q, limit_d;

    always_comb begin
        taken_d = 1'b1;
        limit_d = taken_q ? limit_q : filter_cycles(probe_filter_time_i);
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            taken_q <= 1'b0;
            limit_q <= '0;
        end else begin
            taken_q <= taken_d;
            limit_q <= limit_d;
        end
    end

    logic ext_one_f, ext_two_f;

    probe_pin_filter u_filter_one (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .limit_i(limit_q),
        .level_i(ext_one),
        .level_o(ext_one_f)
    );

    probe_pin_filter u_filter_two (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .limit_i(limit_q),
        .level_i(ext_two),
        .level_o(ext_two_f)
    );

    // Object dictionary registers
    logic [15:0] ctrl_q, ctrl_d;
    logic [31:0] req_q, req_d;
    logic [31:0] mask_q, mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic abort_q, abort_d;
    logic [15:0] ctrl_defined;
    logic [15:0] probe_status;
    logic [31:0] input_word;
    logic [31:0] one_rise, one_fall, two_rise, two_fall;

    always_comb begin
        ctrl_defined = '0;
        for (int c = 0; c < 2; c++) begin
            ctrl_defined[c*CH_BYTE + CTL_ENABLE] = 1'b1;
            ctrl_defined[c*CH_BYTE + CTL_CONT] = 1'b1;
            ctrl_defined[c*CH_BYTE + CTL_SRC] = 1'b1;
            ctrl_defined[c*CH_BYTE + CTL_RISE] = 1'b1;
            ctrl_defined[c*CH_BYTE + CTL_FALL] = 1'b1;
        end
    end

    always_comb begin
        input_word = '0;
        input_word[IN_NEG_OT] = neg_ot;
        input_word[IN_POS_OT] = pos_ot;
        input_word[IN_HOME] = home;
        input_word[IN_CONN_LSB +: NUM_CONN] = conn;
    end

    // Write wins over a read offered in the same cycle
    always_comb begin
        ctrl_d = ctrl_q;
        req_d = req_q;
        mask_d = mask_q;
        rdata_d = '0;
        ack_d = 1'b0;
        abort_d = 1'b0;
        if (od_req_i.wr) begin
            ack_d = 1'b1;
            if (od_req_i.index == IDX_PROBE_CONTROL
                    && od_req_i.sub == SUB_ENTRY_COUNT) begin
                // Reserved control bits are held at zero
                ctrl_d = od_req_i.wdata[15:0] & ctrl_defined;
            end else if (od_req_i.index == IDX_OUTPUT
                    && od_req_i.sub == SUB_REQUEST) begin
                req_d = od_req_i.wdata;
            end else if (od_req_i.index == IDX_OUTPUT
                    && od_req_i.sub == SUB_MASK) begin
                mask_d = od_req_i.wdata;
            end else begin
                ack_d = 1'b0;
                abort_d = 1'b1;
            end
        end else if (od_req_i.rd) begin
            ack_d = 1'b1;
            case (od_req_i.index)
                IDX_PROBE_CONTROL: rdata_d = {16'h0000, ctrl_q};
                IDX_PROBE_STATUS: rdata_d = {16'h0000, probe_status};
                IDX_ONE_RISE_POS: rdata_d = one_rise;
                IDX_ONE_FALL_POS: rdata_d = one_fall;
                IDX_TWO_RISE_POS: rdata_d = two_rise;
                IDX_TWO_FALL_POS: rdata_d = two_fall;
                IDX_INPUT_STATUS: rdata_d = input_word;
                IDX_OUTPUT: begin
                    if (od_req_i.sub == SUB_ENTRY_COUNT) begin
                        rdata_d = {24'h000000, OUTPUT_ENTRY_COUNT};
                    end else if (od_req_i.sub == SUB_REQUEST) begin
                        rdata_d = req_q;
                    end else if (od_req_i.sub == SUB_MASK) begin
                        rdata_d = mask_q;
                    end else begin
                        ack_d = 1'b0;
                        abort_d = 1'b1;
                    end
                end
                default: begin
                    ack_d = 1'b0;
                    abort_d = 1'b1;
                end
            endcase
            if (od_req_i.index != IDX_OUTPUT
                    && od_req_i.sub != SUB_ENTRY_COUNT) begin
                ack_d = 1'b0;
                abort_d = 1'b1;
                rdata_d = '0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CONTROL_RESET;
            req_q <= OUTPUT_RESET;
            mask_q <= OUTPUT_RESET;
            rdata_q <= '0;
            ack_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            req_q <= req_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            abort_q <= abort_d;
        end
    end

    // Probe channels share the zero pulse but keep their own pins
    probe_latch_channel u_probe_one (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .ctrl_i(decode_ctrl(ctrl_q[7:0])),
        .ext_i(ext_one_f),
        .zero_i(zero_pulse),
        .position_i(feedback_position_i),
        .status_o(probe_status[7:0]),
        .rise_pos_o(one_rise),
        .fall_pos_o(one_fall)
    );

    probe_latch_channel u_probe_two (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .ctrl_i(decode_ctrl(ctrl_q[15:8])),
        .ext_i(ext_two_f),
        .zero_i(zero_pulse),
        .position_i(feedback_position_i),
        .status_o(probe_status[15:8]),
        .rise_pos_o(two_rise),
        .fall_pos_o(two_fall)
    );

    // Pin outputs
    logic [NUM_CONN-1:0] gp_q, gp_d;
    logic [NUM_REMOTE-1:0] rem_q, rem_d;
    logic [NUM_CONN-1:0] din_q, din_d;
    logic gp_active;

    always_comb begin
        gp_d = '0;
        rem_d = '0;
        gp_active = 1'b0;
        for (int n = 0; n < NUM_CONN; n++) begin
            if (mask_q[OUT_GP_LSB + n] && bus_output_enable_i[n]) begin
                gp_active = !req_q[OUT_GP_LSB + n];
            end else begin
                gp_active = internal_out_active_i[n];
            end
            // Polarity 0 drives the pin low when active
            gp_d[n] = output_polarity_i[n] ? gp_active : !gp_active;
        end
        for (int r = 0; r < NUM_REMOTE; r++) begin
            rem_d[r] = remote_output_allocation_i[r]
                && mask_q[OUT_REMOTE_LSB + r]
                && !req_q[OUT_REMOTE_LSB + r];
        end
        // Connector inputs are low-active; remote ones stay host-only
        din_d = ~conn & ~remote_input_sel_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gp_q <= '0;
            rem_q <= '0;
            din_q <= '0;
        end else begin
            gp_q <= gp_d;
            rem_q <= rem_d;
            din_q <= din_d;
        end
    end

    assign od_rdata_o = rdata_q;
    assign od_ack_o = ack_q;
    assign od_abort_o = abort_q;
    assign drive_input_active_o = din_q;
    assign general_out_o = gp_q;
    assign remote_out_o = rem_q;
endmodule // io_status_probe_top
`default_nettype wire

// *** hw/probe_latch_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
module probe_latch_channel (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire io_probe_pkg::probe_ctrl_type ctrl_i,
    input wire logic ext_i,
    input wire logic zero_i,
    input wire logic [31:0] position_i,
    output logic [7:0] status_o,
    output logic [31:0] rise_pos_o,
    output logic [31:0] fall_pos_o
);
    import io_probe_pkg::*;

    logic trig_q, trig_d;
    logic en_q, en_d;
    logic rise_flag_q, rise_flag_d;
    logic fall_flag_q, fall_flag_d;
    logic [1:0] count_q, count_d;
    logic [31:0] rise_pos_q, rise_pos_d;
    logic [31:0] fall_pos_q, fall_pos_d;
    logic trig, take_rise, take_fall;

    always_comb begin
        trig = ctrl_i.zero_src ? zero_i : ext_i;
        trig_d = trig;
        en_d = ctrl_i.enable;
        take_rise = ctrl_i.enable && ctrl_i.rise_en && trig && !trig_q
            && (ctrl_i.continuous || !rise_flag_q);
        take_fall = ctrl_i.enable && ctrl_i.fall_en && !trig && trig_q
            && (ctrl_i.continuous || !fall_flag_q);
        rise_flag_d = rise_flag_q | take_rise;
        fall_flag_d = fall_flag_q | take_fall;
        count_d = count_q;
        if (ctrl_i.continuous && (take_rise || take_fall)) begin
            count_d = count_q + 2'd1;
        end
        rise_pos_d = take_rise ? position_i : rise_pos_q;
        fall_pos_d = take_fall ? position_i : fall_pos_q;
        // Positions survive a disable so the host can still read them
        if (!ctrl_i.enable) begin
            rise_flag_d = 1'b0;
            fall_flag_d = 1'b0;
            count_d = 2'd0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_q <= 1'b0;
            en_q <= 1'b0;
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
            count_q <= 2'd0;
            rise_pos_q <= '0;
            fall_pos_q <= '0;
        end else begin
            trig_q <= trig_d;
            en_q <= en_d;
            rise_flag_q <= rise_flag_d;
            fall_flag_q <= fall_flag_d;
            count_q <= count_d;
            rise_pos_q <= rise_pos_d;
            fall_pos_q <= fall_pos_d;
        end
    end

    always_comb begin
        status_o = '0;
        status_o[ST_ENABLED] = en_q;
        status_o[ST_RISE] = rise_flag_q;
        status_o[ST_FALL] = fall_flag_q;
        status_o[ST_COUNT_LSB +: 2] = count_q;
    end

    assign rise_pos_o = rise_pos_q;
    assign fall_pos_o = fall_pos_q;
endmodule // probe_latch_channel
`default_nettype wire

// *** hw/probe_pin_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module probe_pin_filter (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [io_probe_pkg::FILTER_CNT_W-1:0] limit_i,
    input wire logic level_i,
    output logic level_o
);
    import io_probe_pkg::*;

    logic [FILTER_CNT_W-1:0] cnt_q, cnt_d;
    logic level_q, level_d;

    // A new level must hold for limit_i cycles before it is passed on
    always_comb begin
        cnt_d = '0;
        level_d = level_q;
        if (level_i != level_q) begin
            if (cnt_q >= limit_i) begin
                level_d = level_i;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            level_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            level_q <= level_d;
        end
    end

    assign level_o = level_q;
endmodule // probe_pin_filter
`default_nettype wire

// *** pkg/io_probe_pkg.sv ***
`default_nettype none
package io_probe_pkg;
    // Object dictionary indices and subindices
    localparam logic [15:0] IDX_PROBE_CONTROL = 16'h60b8;
    localparam logic [15:0] IDX_PROBE_STATUS = 16'h60b9;
    localparam logic [15:0] IDX_ONE_RISE_POS = 16'h60ba;
    localparam logic [15:0] IDX_ONE_FALL_POS = 16'h60bb;
    localparam logic [15:0] IDX_TWO_RISE_POS = 16'h60bc;
    localparam logic [15:0] IDX_TWO_FALL_POS = 16'h60bd;
    localparam logic [15:0] IDX_INPUT_STATUS = 16'h60fd;
    localparam logic [15:0] IDX_OUTPUT = 16'h60fe;
    localparam logic [7:0] SUB_ENTRY_COUNT = 8'h00;
    localparam logic [7:0] SUB_REQUEST = 8'h01;
    localparam logic [7:0] SUB_MASK = 8'h02;
    localparam logic [7:0] OUTPUT_ENTRY_COUNT = 8'h02;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [31:0] OUTPUT_RESET = 32'h0000_0000;
    // Input status word layout
    localparam int IN_NEG_OT = 0;
    localparam int IN_POS_OT = 1;
    localparam int IN_HOME = 2;
    localparam int IN_CONN_LSB = 16;
    // Output word layout
    localparam int NUM_CONN = 5;
    localparam int NUM_REMOTE = 2;
    localparam int OUT_GP_LSB = 16;
    localparam int OUT_REMOTE_LSB = 24;
    // Probe control and status byte layout, channel two one byte higher
    localparam int CH_BYTE = 8;
    localparam int CTL_ENABLE = 0;
    localparam int CTL_CONT = 1;
    localparam int CTL_SRC = 2;
    localparam int CTL_RISE = 4;
    localparam int CTL_FALL = 5;
    localparam int ST_ENABLED = 0;
    localparam int ST_RISE = 1;
    localparam int ST_FALL = 2;
    localparam int ST_COUNT_LSB = 6;
    // Probe input filter timing
    localparam int FILTER_UNIT_NS = 10;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [7:0] FILTER_TIME_MAX = 8'hc8;
    localparam int FILTER_CNT_W = 9;

    typedef struct packed {
        logic enable;
        logic continuous;
        logic zero_src;
        logic rise_en;
        logic fall_en;
    } probe_ctrl_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } od_req_type;

    function automatic probe_ctrl_type decode_ctrl(input logic [7:0] b);
        probe_ctrl_type c;
        c.enable = b[CTL_ENABLE];
        c.continuous = b[CTL_CONT];
        c.zero_src = b[CTL_SRC];
        c.rise_en = b[CTL_RISE];
        c.fall_en = b[CTL_FALL];
        return c;
    endfunction

    // Least filter time, rounded up to whole clock cycles
    function automatic logic [FILTER_CNT_W-1:0] filter_cycles(input logic [7:0] t);
        int unsigned tc;
        tc = 32'((t > FILTER_TIME_MAX) ? FILTER_TIME_MAX : t);
        tc = (tc * FILTER_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return tc[FILTER_CNT_W-1:0];
    endfunction
endpackage
`default_nettype wire

// *** sim/io_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module io_host_model
    import io_probe_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic [31:0] rdata_i,
    input wire logic ack_i,
    input wire logic abort_i,
    output var io_probe_pkg::od_req_type req_o
);
    initial req_o = '0;
    // One-cycle request; the answer is taken at the next falling edge, half a cycle after the taking edge
    // Callers build wdata with reserved bits zero, save two deliberate cases
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
            input logic [31:0] wdata, output logic [31:0] rdata, output logic [1:0] resp);
        @(negedge core_clk_i);
        req_o = '{wr: wr, rd: !wr, index: idx, sub: sub, wdata: wdata};
        @(negedge core_clk_i);
        rdata = rdata_i;
        resp = {ack_i, abort_i};
        // Released lines show the inverse rather than a stale copy
        req_o = '{wr: 1'b0, rd: 1'b0, index: ~idx, sub: ~sub, wdata: ~wdata};
    endtask
endmodule // io_host_model
`default_nettype wire

// *** sim/io_status_probe_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module io_status_probe_checker
    import io_probe_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire io_probe_pkg::od_req_type od_req_i,
    input wire logic [31:0] od_rdata_o,
    input wire logic od_ack_o,
    input wire logic od_abort_o,
    input wire logic [NUM_CONN-1:0] remote_input_sel_i,
    input wire logic [NUM_CONN-1:0] bus_output_enable_i,
    input wire logic [NUM_CONN-1:0] output_polarity_i,
    input wire logic [NUM_REMOTE-1:0] remote_output_allocation_i,
    input wire logic [NUM_CONN-1:0] internal_out_active_i,
    input wire logic [NUM_CONN-1:0] drive_input_active_o,
    input wire logic [NUM_CONN-1:0] general_out_o,
    input wire logic [NUM_REMOTE-1:0] remote_out_o
);
    // Checks wait out the reset synchroniser and the first output update
    logic [2:0] up_q;
    logic [2:0] up_d;
    logic rdy;
    logic req;
    logic rd;
    always_comb begin
        up_d = up_q + {2'b00, ~&up_q};
    end
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            up_q <= 3'h0;
        end else begin
            up_q <= up_d;
        end
    end
    assign rdy = &up_q;
    assign req = od_req_i.wr | od_req_i.rd;
    assign rd = rdy && od_req_i.rd && !od_req_i.wr && od_req_i.sub == SUB_ENTRY_COUNT;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_answer_once:
        assert property (rdy |=> (od_ack_o || od_abort_o) == $past(req) && !(od_ack_o && od_abort_o))
        else $error("object access not answered exactly once");
    a_entry_count_two:
        assert property (rd && od_req_i.index == IDX_OUTPUT |=> od_ack_o && od_rdata_o == 32'h2)
        else $error("output entry count read wrong");
    a_position_read_only:
        assert property (rdy && od_req_i.wr
            && od_req_i.index inside {[IDX_ONE_RISE_POS:IDX_TWO_FALL_POS]} |=> od_abort_o)
        else $error("write to a captured position accepted");
    a_input_reserved_zero:
        assert property (rd && od_req_i.index == IDX_INPUT_STATUS
            |=> od_ack_o && od_rdata_o[15:3] == 13'h0 && od_rdata_o[31:21] == 11'h0)
        else $error("input status reserved bits set");
    a_status_reserved_zero:
        assert property (rd && od_req_i.index == IDX_PROBE_STATUS
            |=> od_ack_o && (od_rdata_o & 32'hffff_3838) == 32'h0)
        else $error("probe status reserved bits set");
    a_remote_input_hidden:
        assert property ((rdy && $stable(remote_input_sel_i))[*3]
            |-> (drive_input_active_o & remote_input_sel_i) == 5'h0)
        else $error("remote input reached a drive function");
    a_remote_output_alloc:
        assert property ((rdy && $stable(remote_output_allocation_i))[*3]
            |-> (remote_out_o & ~remote_output_allocation_i) == 2'h0)
        else $error("unallocated remote output active");
    a_internal_outputs:
        assert property ((rdy && bus_output_enable_i == 5'h0 && $stable(internal_out_active_i)
            && $stable(output_polarity_i))[*3]
            |-> general_out_o == ~(internal_out_active_i ^ output_polarity_i))
        else $error("general output not under internal control");
endmodule // io_status_probe_checker
`default_nettype wire

// *** sim/io_status_probe_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
    end \
end
module io_status_probe_top_tb_top;
    import io_probe_pkg::*;
    localparam logic [1:0] ACK = 2'b10;
    localparam logic [1:0] ABT = 2'b01;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    od_req_type req;
    logic [31:0] rdata;
    logic ack, abort;
    logic neg_ot = 0, pos_ot = 0, home = 0, p1 = 0, p2 = 0, zero = 0;
    logic [31:0] pos = '0;
    logic [4:0] conn = '1, rsel = '0, ben = '0, pol = '0, intl = '0, drv, gout;
    logic [1:0] ralloc = '0, rout;
    int failures = 0;
    int n_tests = 0;
    always #2 clk = ~clk;

    io_status_probe_top i_dut (.core_clk_i(clk), .rstn_i(rstn), .od_req_i(req),
        .od_rdata_o(rdata), .od_ack_o(ack), .od_abort_o(abort), .neg_overtravel_i(neg_ot),
        .positive_overtravel_i(pos_ot), .home_switch_i(home), .connector_in_i(conn),
        .probe_input_one_i(p1), .probe_input_two_i(p2), .encoder_zero_i(zero),
        .feedback_position_i(pos), .remote_input_sel_i(rsel), .bus_output_enable_i(ben),
        .output_polarity_i(pol), .remote_output_allocation_i(ralloc),
        .internal_out_active_i(intl), .probe_filter_time_i(8'h04),
        .drive_input_active_o(drv), .general_out_o(gout), .remote_out_o(rout));
    io_host_model i_host (.core_clk_i(clk), .rdata_i(rdata), .ack_i(ack), .abort_i(abort),
        .req_o(req));

    task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
            input logic [1:0] er);
        logic [31:0] r;
        logic [1:0] s;
        i_host.access(1'b1, idx, sub, d, r, s);
        `CHK("write response", er, s)
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e,
            input logic [1:0] er);
        logic [31:0] r;
        logic [1:0] s;
        i_host.access(1'b0, idx, sub, 32'h0, r, s);
        `CHK("read response", er, s)
        `CHK("read data", e, r)
    endtask
    // Position is held until the filtered edge has certainly been captured
    task automatic step(input logic [31:0] p, input logic a, input logic b, input logic z);
        pos = p;
        p1 = a;
        p2 = b;
        zero = z;
        repeat (20) @(negedge clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #40000;
        failures++;
        results();
    end

    initial begin
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
        rd(IDX_PROBE_CONTROL, 8'h00, 32'h0, ACK);
        rd(IDX_OUTPUT, SUB_REQUEST, 32'h0, ACK);
        rd(IDX_OUTPUT, SUB_ENTRY_COUNT, 32'h2, ACK);
        rd(IDX_OUTPUT, 8'h03, 32'h0, ABT);
        rd(16'h6000, 8'h00, 32'h0, ABT);
        wr(IDX_ONE_FALL_POS, 8'h00, 32'h1234_5678, ABT);
        wr(IDX_PROBE_STATUS, 8'h00, 32'hffff, ABT);
        wr(IDX_PROBE_CONTROL, 8'h00, 32'hffff, ACK);
        rd(IDX_PROBE_CONTROL, 8'h00, 32'h3737, ACK);
        wr(IDX_PROBE_CONTROL, 8'h00, 32'h0, ACK);
        $display("test registers done");
        neg_ot = 1'b1;
        home = 1'b1;
        conn = 5'b10110;
        rsel = 5'b00011;
        repeat (6) @(negedge clk);
        rd(IDX_INPUT_STATUS, 8'h00, 32'h0016_0005, ACK);
        `CHK("drive inputs", 5'b01000, drv)
        $display("test inputs done");
        ben = 5'b00111;
        pol = 5'b00101;
        intl = 5'b11000;
        ralloc = 2'b01;
        wr(IDX_OUTPUT, SUB_REQUEST, 32'h000a_0000, ACK);
        wr(IDX_OUTPUT, SUB_MASK, 32'h031f_0000, ACK);
        repeat (3) @(negedge clk);
        `CHK("general outputs", 5'b00111, gout)
        `CHK("remote outputs", 2'b01, rout)
        rd(IDX_OUTPUT, SUB_MASK, 32'h031f_0000, ACK);
        wr(IDX_OUTPUT, SUB_MASK, 32'h0, ACK);
        repeat (3) @(negedge clk);
        `CHK("masked general", 5'b00010, gout)
        `CHK("masked remote", 2'b00, rout)
        $display("test outputs done");
        wr(IDX_PROBE_CONTROL, 8'h00, 32'h3731, ACK);
        step(32'h100, 1'b1, 1'b0, 1'b0);
        step(32'h200, 1'b0, 1'b0, 1'b1);
        step(32'h777, 1'b0, 1'b1, 1'b1);
        step(32'h300, 1'b1, 1'b1, 1'b0);
        step(32'h400, 1'b1, 1'b0, 1'b1);
        rd(IDX_PROBE_STATUS, 8'h00, 32'hc707, ACK);
        rd(IDX_ONE_RISE_POS, 8'h00, 32'h100, ACK);
        rd(IDX_ONE_FALL_POS, 8'h00, 32'h200, ACK);
        rd(IDX_TWO_RISE_POS, 8'h00, 32'h400, ACK);
        rd(IDX_TWO_FALL_POS, 8'h00, 32'h300, ACK);
        step(32'hffff_ff00, 1'b1, 1'b0, 1'b0);
        rd(IDX_PROBE_STATUS, 8'h00, 32'h0707, ACK);
        rd(IDX_TWO_FALL_POS, 8'h00, 32'hffff_ff00, ACK);
        wr(IDX_PROBE_CONTROL, 8'h00, 32'h0031, ACK);
        rd(IDX_PROBE_STATUS, 8'h00, 32'h0007, ACK);
        step(32'h555, 1'b1, 1'b0, 1'b1);
        rd(IDX_TWO_RISE_POS, 8'h00, 32'h400, ACK);
        wr(IDX_PROBE_CONTROL, 8'h00, 32'h3030, ACK);
        wr(IDX_PROBE_CONTROL, 8'h00, 32'h3131, ACK);
        // A low pulse shorter than the filter time must not be latched
        pos = 32'h999;
        p1 = 1'b0;
        repeat (5) @(negedge clk);
        p1 = 1'b1;
        repeat (20) @(negedge clk);
        rd(IDX_PROBE_STATUS, 8'h00, 32'h0101, ACK);
        rd(IDX_ONE_FALL_POS, 8'h00, 32'h200, ACK);
        step(32'h666, 1'b0, 1'b1, 1'b1);
        rd(IDX_PROBE_STATUS, 8'h00, 32'h0305, ACK);
        rd(IDX_ONE_FALL_POS, 8'h00, 32'h666, ACK);
        rd(IDX_TWO_RISE_POS, 8'h00, 32'h666, ACK);
        $display("test probe done");
        results();
    end
endmodule // io_status_probe_top_tb_top
bind io_status_probe_top io_status_probe_checker i_chk (.core_clk_i, .rstn_i, .od_req_i,
    .od_rdata_o, .od_ack_o, .od_abort_o, .remote_input_sel_i, .bus_output_enable_i,
    .output_polarity_i, .remote_output_allocation_i, .internal_out_active_i,
    .drive_input_active_o, .general_out_o, .remote_out_o);
`default_nettype wire
